// File: src/cdl_regs.vh
`ifndef CDL_REGS_VH
`define CDL_REGS_VH

// ==========================================================
// register offsets, owning-core system register space
`define CDL_CH0_TX_CTL    8'h10
`define CDL_CH0_RX_CTL    8'h11
`define CDL_CH0_TX_WORD   8'h12
`define CDL_CH0_RX_WORD   8'h13
`define CDL_CH1_TX_CTL    8'h20
`define CDL_CH1_RX_CTL    8'h21
`define CDL_CH1_TX_WORD   8'h22
`define CDL_CH1_RX_WORD   8'h23
`define CDL_CH_STRIDE     8'h10
`define CDL_CTL_RESET     16'h0000

// ==========================================================
// channel control field positions
`define CDL_B_CONNECT     0
`define CDL_B_DMA_MIRROR  1
`define CDL_B_FLUSH       2
`define CDL_B_DSP         3
`define CDL_B_SLOT_LO     4
`define CDL_B_SLOT_HI     7
`define CDL_B_FIP_LO      8
`define CDL_B_FIP_HI      10
`define CDL_B_DMA         11
`define CDL_B_LOOP        12
`define CDL_B_FULL        13
`define CDL_B_EMPTY       14
`define CDL_B_FLOW        15

// ==========================================================
// codec frame layout in bit clocks
`define CDL_FRAME_LAST    8'hff
`define CDL_TAG_BITS      9'h010
`define CDL_SLOT_BITS     9'h014
`define CDL_SLOT_CMD_ADDR 4'h1
`define CDL_SLOT_CMD_DATA 4'h2
`define CDL_SLOT_FIRST_PCM 4'h3
`define CDL_SLOT_LAST     4'hc

// ==========================================================
// timing
`define CDL_CLK_NS        20
`define CDL_WR2_BITCLKS   4'h3
`define CDL_READ_BEST_NS  25390
`define CDL_READ_MAX_NS   87890
`define CDL_READ_MAX_CYC  (`CDL_READ_MAX_NS / `CDL_CLK_NS)

`endif

// File: src/cdl_sync.v
`timescale 1ns/1ps
module cdl_sync #(
  parameter WIDTH = 2
) (
  // clock and reset
  input  wire             clk,
  input  wire             reset_n,
  // asynchronous levels in, synchronous levels out
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // ==========================================================
  // two flops per bit; only the second one is visible
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] stable_q;

  always @(posedge clk) begin
    if (!reset_n) begin
      meta_q   <= {WIDTH{1'b0}};
      stable_q <= {WIDTH{1'b0}};
    end else begin
      meta_q   <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule

// File: src/cdl_wq.v
`timescale 1ns/1ps
module cdl_wq (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // fill side
  input  wire        push,
  input  wire [22:0] push_data,
  // drain side
  input  wire        pop,
  output wire [22:0] head,
  output wire [1:0]  count
);

  // ==========================================================
  // two-entry posted write store, entry 0 is the oldest
  reg [22:0] ent_q [0:1];
  reg [1:0]  cnt_q;

  always @(posedge clk) begin
    if (!reset_n) begin
      ent_q[0] <= 23'h000000;
      ent_q[1] <= 23'h000000;
      cnt_q    <= 2'h0;
    end else begin
      if (pop && cnt_q != 2'h0) begin
        ent_q[0] <= (push && cnt_q == 2'h1) ? push_data : ent_q[1];
        if (!push)
          cnt_q <= cnt_q - 2'h1;
      end else if (push && cnt_q != 2'h2) begin
        if (cnt_q == 2'h0)
          ent_q[0] <= push_data;
        else
          ent_q[1] <= push_data;
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end

  assign head  = ent_q[0];
  assign count = cnt_q;

endmodule

// File: src/cdl_link.v
// Overview of operation
// - codec writes posted, one sent per frame
// - at most two codec writes held pending
// - write into empty queue takes no waits
// - second write waits a few bit clocks
// - third pending write stalls until frame frees
// - codec reads stall master until data returns
// - read starts after pending writes finish
// - unqueued read takes one to two frames three slots
// - read bounded by four frames three slots
// - stalled access blocks shared bus for everyone
// - channel control reachable from owning core only
// - bit 0 connects channel to link
// - bit 11 enables channel dma servicing
// - bits 10..8 pick interrupt fill position
// - bit 15 sticky flow error, write-one-clear
// - bits 3,2,12 controls; bit 1 mirrors dma
`timescale 1ns/1ps
`include "cdl_regs.vh"
module cdl_link #(
  parameter READ_LIMIT_CYC = `CDL_READ_MAX_CYC
) (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // owning-core system register port
  input  wire [7:0]  sys_addr,
  input  wire        sys_wr,
  input  wire        sys_rd,
  input  wire        sys_from_host,
  input  wire [15:0] sys_wdata,
  output reg  [15:0] sys_rdata,
  // peripheral control bus, codec register window
  input  wire        pcb_req,
  input  wire        pcb_write,
  input  wire [6:0]  pcb_addr,
  input  wire [15:0] pcb_wdata,
  output wire        pcb_wait,
  output wire        pcb_bus_locked,
  output reg  [15:0] pcb_rdata,
  output reg         pcb_rvalid,
  // channel service
  output reg  [3:0]  chan_irq,
  output reg  [3:0]  chan_dma_req,
  // codec link
  input  wire        codec_bit_clock,
  input  wire        codec_sdata_in,
  output reg         codec_sync,
  output reg         codec_sdata_out
);

  // ==========================================================
  // slot geometry helpers
  function [3:0] slot_of;
    input [7:0] b;
    reg   [8:0] off;
    reg   [7:0] idx;
    begin
      off = {1'b0, b} - `CDL_TAG_BITS;
      idx = off[7:0] / 8'd20;
      if ({1'b0, b} < `CDL_TAG_BITS)
        slot_of = 4'h0;
      else
        slot_of = 4'h1 + idx[3:0];
    end
  endfunction

  function is_first;
    input [7:0] b;
    reg   [8:0] off;
    begin
      off = {1'b0, b} - `CDL_TAG_BITS;
      if ({1'b0, b} < `CDL_TAG_BITS)
        is_first = (b == 8'h00);
      else
        is_first = (off[7:0] % 8'd20 == 8'd0);
    end
  endfunction

  function is_last;
    input [7:0] b;
    reg   [8:0] off;
    begin
      off = {1'b0, b} - `CDL_TAG_BITS;
      if ({1'b0, b} < `CDL_TAG_BITS)
        is_last = (b == 8'h0f);
      else
        is_last = (off[7:0] % 8'd20 == 8'd19);
    end
  endfunction

  // ==========================================================
  // link input sampling and edge finding
  wire [1:0] link_s;
  reg        bclk_d_q;

  cdl_sync #(.WIDTH(2)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({codec_sdata_in, codec_bit_clock}),
    .sync_out (link_s)
  );

  wire bclk_rise = link_s[0] & ~bclk_d_q;
  wire bclk_fall = ~link_s[0] & bclk_d_q;

  reg  [7:0] bit_q;
  wire [7:0] nb          = bit_q + 8'h01;
  wire       frame_start = bclk_rise && bit_q == `CDL_FRAME_LAST;
  wire       slot_load   = bclk_rise && is_first(nb);
  wire [3:0] load_slot   = slot_of(nb);
  wire       slot_end    = bclk_fall && is_last(bit_q);
  wire [3:0] end_slot    = slot_of(bit_q);

  // ==========================================================
  // codec command path
  localparam RD_IDLE   = 3'h0;
  localparam RD_QUEUED = 3'h1;
  localparam RD_SENT   = 3'h2;
  localparam RD_REPLY  = 3'h3;
  localparam RD_DONE   = 3'h4;

  reg  [2:0]  rd_state_q;
  reg  [6:0]  rd_addr_q;
  reg  [15:0] rd_data_q;
  reg  [15:0] rd_timer_q;
  reg  [3:0]  gap_q;
  reg  [19:0] in_sr_q;
  reg         cmd_read_q;
  reg  [6:0]  cmd_addr_q;
  reg  [15:0] cmd_data_q;
  wire [22:0] wq_head;
  wire [1:0]  wq_count;

  wire wr_wait = (wq_count == 2'h2) ||
                 (wq_count == 2'h1 && gap_q < `CDL_WR2_BITCLKS) ||
                 (rd_state_q != RD_IDLE);
  wire rd_wait = (rd_state_q != RD_DONE);
  assign pcb_wait       = pcb_req && (pcb_write ? wr_wait : rd_wait);
  assign pcb_bus_locked = pcb_wait;

  wire wr_take  = pcb_req && pcb_write && !wr_wait;
  wire wq_pop   = frame_start && wq_count != 2'h0;
  wire rd_start = frame_start && wq_count == 2'h0 &&
                  rd_state_q == RD_QUEUED;

  cdl_wq u_wq (
    .clk       (clk),
    .reset_n   (reset_n),
    .push      (wr_take),
    .push_data ({pcb_addr, pcb_wdata}),
    .pop       (wq_pop),
    .head      (wq_head),
    .count     (wq_count)
  );

  always @(posedge clk) begin
    if (!reset_n) begin
      bclk_d_q    <= 1'b0;
      bit_q       <= `CDL_FRAME_LAST;
      gap_q       <= 4'h0;
      cmd_read_q  <= 1'b0;
      cmd_addr_q  <= 7'h00;
      cmd_data_q  <= 16'h0000;
      rd_state_q  <= RD_IDLE;
      rd_addr_q   <= 7'h00;
      rd_data_q   <= 16'h0000;
      rd_timer_q  <= 16'h0000;
      pcb_rdata   <= 16'h0000;
      pcb_rvalid  <= 1'b0;
    end else begin
      bclk_d_q   <= link_s[0];
      pcb_rvalid <= 1'b0;
      if (bclk_rise)
        bit_q <= nb;
      // write spacing is counted in bit clocks since the last accept
      if (wr_take)
        gap_q <= 4'h0;
      else if (bclk_rise && gap_q != 4'hf)
        gap_q <= gap_q + 4'h1;
      // one command per frame: a queued write first, then a waiting read
      if (frame_start) begin
        cmd_read_q  <= !wq_pop && rd_start;
        cmd_addr_q  <= wq_pop ? wq_head[22:16] : rd_addr_q;
        cmd_data_q  <= wq_pop ? wq_head[15:0] : 16'h0000;
      end
      case (rd_state_q)
        RD_IDLE: begin
          if (pcb_req && !pcb_write) begin
            rd_state_q <= RD_QUEUED;
            rd_addr_q  <= pcb_addr;
          end
        end
        RD_QUEUED: begin
          if (rd_start)
            rd_state_q <= RD_SENT;
        end
        RD_SENT: begin
          // reply arrives in slot 2 of the frame after the request
          if (frame_start)
            rd_state_q <= RD_REPLY;
        end
        RD_REPLY: begin
          if (slot_end && end_slot == `CDL_SLOT_CMD_DATA) begin
            // the slot's last bit is shifted in on this same edge
            rd_data_q  <= in_sr_q[18:3];
            rd_state_q <= RD_DONE;
          end
        end
        RD_DONE: begin
          rd_state_q <= RD_IDLE;
          pcb_rdata  <= rd_data_q;
          pcb_rvalid <= 1'b1;
        end
        default: rd_state_q <= RD_IDLE;
      endcase
      // a dead bit clock must not hang the shared bus forever
      if (rd_state_q == RD_IDLE || rd_state_q == RD_DONE)
        rd_timer_q <= 16'h0000;
      else if (rd_timer_q >= READ_LIMIT_CYC[15:0]) begin
        rd_data_q  <= 16'hffff;
        rd_state_q <= RD_DONE;
      end else
        rd_timer_q <= rd_timer_q + 16'h0001;
    end
  end

  // ==========================================================
  // channel registers; 0 ch0 tx, 1 ch0 rx, 2 ch1 tx, 3 ch1 rx
  reg  [15:0] ctl_rd   [0:3];
  reg  [15:0] word_q   [0:3];
  reg  [3:0]  full_q;
  reg  [3:0]  connect_q;
  reg  [3:0]  slot_q   [0:3];
  wire        sys_ok = !sys_from_host;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_chan
      localparam [7:0] CTL_A  = `CDL_CH0_TX_CTL + `CDL_CH_STRIDE * (i / 2) + (i % 2);
      localparam [7:0] WORD_A = CTL_A + 8'h02;
      localparam       IS_TX  = (i % 2 == 0);

      reg        dma_q;
      reg        flush_q;
      reg        dsp_q;
      reg        loop_q;
      reg  [2:0] fip_q;
      reg        flow_q;

      wire ctl_wr  = sys_ok && sys_wr && sys_addr == CTL_A;
      wire word_wr = sys_ok && sys_wr && sys_addr == WORD_A && IS_TX;
      wire word_rd = sys_ok && sys_rd && sys_addr == WORD_A && !IS_TX;
      // tag and command slots never carry channel data
      wire hit_tx  = IS_TX && slot_load && connect_q[i] && load_slot == slot_q[i] &&
                     load_slot >= `CDL_SLOT_FIRST_PCM;
      wire hit_rx  = !IS_TX && slot_end && connect_q[i] && end_slot == slot_q[i] &&
                     end_slot >= `CDL_SLOT_FIRST_PCM;
      wire err     = (hit_tx && !full_q[i]) ||
                     (hit_rx && full_q[i] && !word_rd) ||
                     (word_wr && full_q[i]);

      always @(posedge clk) begin
        if (!reset_n) begin
          connect_q[i] <= 1'b0;
          dma_q        <= 1'b0;
          flush_q      <= 1'b0;
          dsp_q        <= 1'b0;
          loop_q       <= 1'b0;
          fip_q        <= 3'h0;
          slot_q[i]    <= 4'h0;
          flow_q       <= 1'b0;
          full_q[i]    <= 1'b0;
          word_q[i]    <= 16'h0000;
          chan_irq[i]  <= 1'b0;
          chan_dma_req[i] <= 1'b0;
        end else begin
          if (ctl_wr) begin
            connect_q[i] <= sys_wdata[`CDL_B_CONNECT];
            dma_q        <= sys_wdata[`CDL_B_DMA];
            fip_q        <= sys_wdata[`CDL_B_FIP_HI:`CDL_B_FIP_LO];
            slot_q[i]    <= sys_wdata[`CDL_B_SLOT_HI:`CDL_B_SLOT_LO];
            flush_q      <= sys_wdata[`CDL_B_FLUSH];
            dsp_q        <= sys_wdata[`CDL_B_DSP];
            loop_q       <= sys_wdata[`CDL_B_LOOP];
          end
          // an error in the same cycle as the clearing write keeps the flag
          if (err)
            flow_q <= 1'b1;
          else if (ctl_wr && sys_wdata[`CDL_B_FLOW])
            flow_q <= 1'b0;
          // one-word holding stage; flush empties it while set
          if (flush_q)
            full_q[i] <= 1'b0;
          else if (word_wr && !full_q[i]) begin
            word_q[i] <= sys_wdata;
            full_q[i] <= 1'b1;
          end else if (hit_tx)
            full_q[i] <= 1'b0;
          else if (hit_rx && (!full_q[i] || word_rd)) begin
            word_q[i] <= in_sr_q[18:3];
            full_q[i] <= 1'b1;
          end else if (word_rd)
            full_q[i] <= 1'b0;
          chan_irq[i] <= connect_q[i] && {2'b00, full_q[i]} == fip_q;
          chan_dma_req[i] <= dma_q && connect_q[i] &&
                             (IS_TX ? !full_q[i] : full_q[i]);
        end
      end

      always @* begin
        ctl_rd[i] = {flow_q, !full_q[i], full_q[i], loop_q, dma_q, fip_q,
                     slot_q[i], dsp_q, flush_q, dma_q, connect_q[i]};
      end
    end
  endgenerate

  // ==========================================================
  // register read port; host side sees zeros here
  always @(posedge clk) begin
    if (!reset_n)
      sys_rdata <= 16'h0000;
    else if (sys_rd && sys_ok) begin
      case (sys_addr)
        `CDL_CH0_TX_CTL:  sys_rdata <= ctl_rd[0];
        `CDL_CH0_RX_CTL:  sys_rdata <= ctl_rd[1];
        `CDL_CH0_RX_WORD: sys_rdata <= word_q[1];
        `CDL_CH1_TX_CTL:  sys_rdata <= ctl_rd[2];
        `CDL_CH1_RX_CTL:  sys_rdata <= ctl_rd[3];
        `CDL_CH1_RX_WORD: sys_rdata <= word_q[3];
        default:          sys_rdata <= 16'h0000;
      endcase
    end else
      sys_rdata <= 16'h0000;
  end

  // ==========================================================
  // outgoing slot assembly
  reg [19:0] slot_word;
  reg [9:0]  pcm_valid;
  integer    c;
  integer    s;

  always @* begin
    slot_word = 20'h00000;
    pcm_valid = 10'h000;
    for (s = 0; s < 10; s = s + 1) begin
      for (c = 0; c < 4; c = c + 2) begin
        if (connect_q[c] && full_q[c] && slot_q[c] == s[3:0] + `CDL_SLOT_FIRST_PCM)
          pcm_valid[9 - s] = 1'b1;
      end
    end
    if (load_slot == 4'h0)
      slot_word = {1'b1, wq_count != 2'h0 || rd_start, wq_count != 2'h0,
                   pcm_valid, 3'h0, 4'h0};
    else if (load_slot == `CDL_SLOT_CMD_ADDR)
      slot_word = {cmd_read_q, cmd_addr_q, 12'h000};
    else if (load_slot == `CDL_SLOT_CMD_DATA)
      slot_word = {cmd_data_q, 4'h0};
    else begin
      for (c = 0; c < 4; c = c + 2) begin
        if (connect_q[c] && full_q[c] && slot_q[c] == load_slot)
          slot_word = slot_word | {word_q[c], 4'h0};
      end
    end
  end

  // ==========================================================
  // link shifters: drive on rising bit clock, sample on falling
  reg [19:0] out_sr_q;

  always @(posedge clk) begin
    if (!reset_n) begin
      out_sr_q        <= 20'h00000;
      in_sr_q         <= 20'h00000;
      codec_sync      <= 1'b0;
      codec_sdata_out <= 1'b0;
    end else begin
      if (bclk_rise) begin
        if (slot_load) begin
          codec_sdata_out <= slot_word[19];
          out_sr_q        <= {slot_word[18:0], 1'b0};
        end else begin
          codec_sdata_out <= out_sr_q[19];
          out_sr_q        <= {out_sr_q[18:0], 1'b0};
        end
        codec_sync <= ({1'b0, nb} < `CDL_TAG_BITS);
      end
      if (bclk_fall)
        in_sr_q <= {in_sr_q[18:0], link_s[1]};
    end
  end

endmodule

// File: dv/cdl_link_assertions.sv
`timescale 1ns/1ps
// ====
// codec bus checker
module cdl_link_assertions #(
  parameter READ_LIMIT_CYC = 4394
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // register port
  input wire logic        sys_rd,
  input wire logic        sys_from_host,
  input wire logic [15:0] sys_rdata,
  // codec bus and link
  input wire logic        pcb_req,
  input wire logic        pcb_write,
  input wire logic        pcb_wait,
  input wire logic        pcb_bus_locked,
  input wire logic        pcb_rvalid,
  input wire logic        codec_sync
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [1:0]  pend_q;
  logic [15:0] rwait_q;
  logic        sync_q;
  wire         wr_take = pcb_req && pcb_write && !pcb_wait;
  wire         rd_take = pcb_req && !pcb_write && !pcb_wait;
  // pops seen a cycle late, so pend_q errs high and never fires early
  wire         pop = codec_sync && !sync_q && pend_q != 2'h0;
  always @(posedge clk) begin
    if (!reset_n) begin
      pend_q  <= 2'h0;
      rwait_q <= 16'h0000;
      sync_q  <= 1'b0;
    end else begin
      pend_q  <= pend_q + {1'b0, wr_take} - {1'b0, pop};
      rwait_q <= (pcb_req && !pcb_write && pcb_wait) ? rwait_q + 16'h0001 : 16'h0000;
      sync_q  <= codec_sync;
    end
  end
  chk_lock_mirror: assert property (pcb_bus_locked == pcb_wait)
    else $error("bus lock differs from wait");
  chk_empty_nowait: assert property (pend_q == 2'h0 && pcb_req && pcb_write |-> !pcb_wait)
    else $error("write into empty queue waited");
  chk_second_held: assert property (wr_take ##1 !pcb_req ##1
    pcb_req && pcb_write && !$rose(codec_sync) |-> pcb_wait)
    else $error("second write not held");
  chk_third_stall: assert property (pend_q == 2'h2 && !codec_sync &&
    pcb_req && pcb_write |-> pcb_wait)
    else $error("write taken with two pending");
  chk_read_waits: assert property (pcb_req && !pcb_write && !$past(pcb_req) |-> pcb_wait)
    else $error("read taken without stall");
  chk_rvalid_pulse: assert property (rd_take |=> pcb_rvalid ##1 !pcb_rvalid)
    else $error("read data pulse wrong");
  chk_rvalid_cause: assert property (pcb_rvalid |-> $past(rd_take))
    else $error("read data without read");
  chk_read_after_wr: assert property (rd_take |-> pend_q == 2'h0)
    else $error("read done with writes pending");
  chk_read_bound: assert property (rwait_q <= READ_LIMIT_CYC + 4)
    else $error("read stall too long");
  chk_host_refused: assert property (sys_rd && sys_from_host |=> sys_rdata == 16'h0000)
    else $error("host read returned data");
  cov_read_taken: cover property (rd_take);
  cov_third_stall: cover property (pend_q == 2'h2 && pcb_req && pcb_write && pcb_wait);
  cov_host_read: cover property (sys_rd && sys_from_host);
endmodule
bind cdl_link cdl_link_assertions #(.READ_LIMIT_CYC(READ_LIMIT_CYC)) i_cdl_link_assertions (
  .clk, .reset_n, .sys_rd, .sys_from_host, .sys_rdata, .pcb_req, .pcb_write,
  .pcb_wait, .pcb_bus_locked, .pcb_rvalid, .codec_sync
);

// File: dv/cdl_codec_model.sv
`timescale 1ns/1ps
// ====
// codec far end
module cdl_codec_model (
  // link
  output logic codec_bit_clock,
  output logic codec_sdata_in,
  input  wire  codec_sync,
  input  wire  codec_sdata_out
);
  logic [7:0]  pos_q = 8'hff;
  logic        sync_q = 1'b0;
  logic        ask_q = 1'b0;
  logic        due_q = 1'b0;
  logic [19:0] sh_q;
  logic [19:0] cmd_q;
  logic [15:0] tag_q;
  logic [15:0] reply_q;
  logic [15:0] regs [0:127];
  logic [7:0]  nxt;
  // the codec bit clock runs free, frames or not
  initial begin
    codec_bit_clock = 1'b0;
    codec_sdata_in  = 1'b0;
    forever #80 codec_bit_clock = ~codec_bit_clock;
  end
  always @(negedge codec_bit_clock) begin
    sync_q <= codec_sync;
    sh_q   <= {sh_q[18:0], codec_sdata_out};
    pos_q  <= (codec_sync && !sync_q) ? 8'h00 : pos_q + 8'h01;
    if (codec_sync && !sync_q) begin
      due_q <= ask_q;
      ask_q <= 1'b0;
    end
    if (pos_q == 8'h0f) tag_q <= sh_q[15:0];
    if (pos_q == 8'h23) cmd_q <= sh_q;
    if (pos_q == 8'h23 && tag_q[14] && sh_q[19]) begin
      ask_q   <= 1'b1;
      reply_q <= regs[sh_q[18:12]];
    end
    if (pos_q == 8'h37 && tag_q[14] && tag_q[13] && !cmd_q[19])
      regs[cmd_q[18:12]] <= sh_q[19:4];
  end
  // reply in slot2 of the next frame; tag bits 15-13 carry the valid flags, elsewhere the line toggles
  always @(posedge codec_bit_clock) begin
    nxt = pos_q + 8'h01;
    if (nxt < 8'h03) codec_sdata_in <= due_q || nxt == 8'h00;
    else if (due_q && nxt >= 8'h24 && nxt <= 8'h33) codec_sdata_in <= reply_q[8'h33 - nxt];
    else codec_sdata_in <= ~codec_sdata_in;
  end
endmodule

// File: dv/codec_link_register_access_test.sv
`timescale 1ns/1ps
`include "cdl_regs.vh"
// ====
// bench top
module codec_link_register_access_test;
  localparam int FRAME = 2048;
  localparam int SLOT3 = 480;
  logic        clk;
  logic        reset_n = 1'b0;
  logic        sys_wr = 1'b0;
  logic        sys_rd = 1'b0;
  logic        sys_from_host = 1'b0;
  logic [7:0]  sys_addr = 8'h00;
  logic [15:0] sys_wdata = 16'h0000;
  logic        pcb_req = 1'b0;
  logic        pcb_write = 1'b0;
  logic [6:0]  pcb_addr = 7'h00;
  logic [15:0] pcb_wdata = 16'h0000;
  wire  [15:0] sys_rdata;
  wire  [15:0] pcb_rdata;
  wire         pcb_wait;
  wire         pcb_bus_locked;
  wire         pcb_rvalid;
  wire  [3:0]  chan_irq;
  wire  [3:0]  chan_dma_req;
  wire         codec_bit_clock;
  wire         codec_sdata_in;
  wire         codec_sync;
  wire         codec_sdata_out;
  int          miscompares = 0;
  int          compares = 0;
  // limit raised so a read behind two writes is not cut short
  cdl_link #(.READ_LIMIT_CYC(12000)) i_cdl_link (
    .clk, .reset_n, .sys_addr, .sys_wr, .sys_rd, .sys_from_host, .sys_wdata,
    .sys_rdata, .pcb_req, .pcb_write, .pcb_addr, .pcb_wdata, .pcb_wait,
    .pcb_bus_locked, .pcb_rdata, .pcb_rvalid, .chan_irq, .chan_dma_req,
    .codec_bit_clock, .codec_sdata_in, .codec_sync, .codec_sdata_out
  );
  cdl_codec_model i_cdl_codec_model (
    .codec_bit_clock, .codec_sdata_in, .codec_sync, .codec_sdata_out
  );
  // ====
  // shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_range(input int v, input int lo, input int hi);
    compares++;
    if (v < lo || v > hi) begin
      miscompares++;
      $display("Error at %0t: cycles %h outside %h to %h", $time, v, lo, hi);
    end
  endtask
  task automatic sys_write(input logic [7:0] a, input logic [15:0] v);
    @(negedge clk);
    sys_addr  = a;
    sys_wdata = v;
    sys_wr    = 1'b1;
    @(negedge clk);
    sys_wr = 1'b0;
  endtask
  task automatic sys_read(input logic [7:0] a, output logic [15:0] v);
    @(negedge clk);
    sys_addr = a;
    sys_rd   = 1'b1;
    @(negedge clk);
    sys_rd = 1'b0;
    v = sys_rdata;
  endtask
  task automatic pcb_op(input logic w, input logic [6:0] a, input logic [15:0] wd,
                        output int lat, output logic [15:0] rd);
    @(negedge clk);
    pcb_req   = 1'b1;
    pcb_write = w;
    pcb_addr  = a;
    pcb_wdata = wd;
    lat = 0;
    #1;
    while (pcb_wait !== 1'b0 && lat < 20000) begin
      @(negedge clk);
      #1;
      lat++;
    end
    @(negedge clk);
    rd = pcb_rdata;
    check({15'h0000, pcb_rvalid}, {15'h0000, !w});
    pcb_req = 1'b0;
  endtask
  task automatic sync_wait;
    int n = 0;
    while (codec_sync !== 1'b0 && n < 3000) begin @(negedge clk); n++; end
    while (codec_sync !== 1'b1 && n < 6000) begin @(negedge clk); n++; end
    check_range(n, 1, 5999);
    repeat (20) @(negedge clk);
  endtask
  task automatic svc(input logic [7:0] a, input logic [15:0] v, input logic [3:0] irq,
                     input logic [3:0] dma);
    sys_write(a, v);
    @(negedge clk);
    check({12'h000, chan_irq}, {12'h000, irq});
    check({12'h000, chan_dma_req}, {12'h000, dma});
  endtask
  // ====
  // scenarios
  task automatic t_regs;
    logic [15:0] d;
    logic [7:0]  a;
    for (int i = 0; i < 4; i++) begin
      a = (i < 2) ? `CDL_CH0_TX_CTL + 8'(i) : `CDL_CH1_TX_CTL + 8'(i - 2);
      sys_read(a, d);
      check(d, `CDL_CTL_RESET | 16'h4000);
      sys_write(a, 16'h7ffe);
      sys_read(a, d);
      check(d, 16'h5ffe);
      sys_from_host = 1'b1;
      sys_write(a, 16'h0000);
      sys_read(a, d);
      check(d, 16'h0000);
      sys_from_host = 1'b0;
      sys_read(a, d);
      check(d, 16'h5ffe);
      sys_write(a, 16'h0000);
    end
    sys_read(8'h14, d);
    check(d, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_service;
    svc(8'h10, 16'h0801, 4'h1, 4'h1);
    svc(8'h10, 16'h0901, 4'h0, 4'h1);
    svc(8'h12, 16'h1234, 4'h1, 4'h0);
    svc(8'h10, 16'h0900, 4'h0, 4'h0);
    $display("t_service done");
  endtask
  task automatic t_flow;
    logic [15:0] d;
    sys_write(8'h20, 16'h0031);
    sys_write(8'h21, 16'h0031);
    repeat (2 * FRAME + 100) @(negedge clk);
    sys_read(8'h21, d);
    check(d, 16'ha031);
    sys_write(8'h20, 16'h0030);
    sys_read(8'h20, d);
    check(d, 16'hc030);
    sys_write(8'h20, 16'h8000);
    sys_write(8'h21, 16'h8000);
    sys_read(8'h20, d);
    check(d, 16'h4000);
    sys_read(8'h21, d);
    check(d, 16'h2000);
    $display("t_flow done");
  endtask
  task automatic t_wr;
    int          l;
    logic [15:0] d;
    sync_wait;
    pcb_op(1'b1, 7'h02, 16'h1111, l, d);
    check_range(l, 0, 0);
    pcb_op(1'b1, 7'h04, 16'h2222, l, d);
    check_range(l, 8, 40);
    pcb_op(1'b1, 7'h02, 16'h3333, l, d);
    check_range(l, 41, FRAME + 40);
    pcb_op(1'b0, 7'h02, 16'h0000, l, d);
    check(d, 16'h3333);
    check_range(l, 2 * FRAME, 4 * FRAME + SLOT3);
    $display("t_wr done");
  endtask
  task automatic t_rd;
    int          l;
    logic [15:0] d;
    sync_wait;
    repeat (FRAME - 320) @(negedge clk);
    pcb_op(1'b0, 7'h04, 16'h0000, l, d);
    check(d, 16'h2222);
    check_range(l, FRAME, FRAME + SLOT3 + 320);
    $display("t_rd done");
  endtask
  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ====
  // run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    // about twice the longest expected run
    #1_000_000;
    miscompares++;
    test_done;
  end
  initial begin
    // two cycles; the synchronisers clear on the synchronous reset
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    t_regs;
    t_service;
    t_flow;
    t_wr;
    t_rd;
    test_done;
  end
endmodule
